// ===== design/toc_defines.svh
`ifndef TOC_DEFINES_SVH
`define TOC_DEFINES_SVH

// Register byte addresses.
`define TOC_ADDR_CTRL      8'h00
`define TOC_ADDR_FORCE     8'h04
`define TOC_ADDR_CMP_A     8'h08
`define TOC_ADDR_CMP_B     8'h0C
`define TOC_ADDR_FLAGS     8'h10
`define TOC_ADDR_IRQ_EN    8'h14
`define TOC_ADDR_STATUS    8'h18

// Control register fields.
`define TOC_CTRL_WGM_LSB   0
`define TOC_CTRL_COMA_LSB  4
`define TOC_CTRL_COMB_LSB  6

// Waveform mode codes.
`define TOC_WGM_NORMAL     3'h0
`define TOC_WGM_MATCH_CLR  3'h2
`define TOC_WGM_FAST       3'h3
`define TOC_WGM_FAST_TOP   3'h7
`define TOC_WGM_PHASE      3'h1
`define TOC_WGM_PHASE_TOP  3'h5

// Compare output mode codes.
`define TOC_COM_OFF        2'h0
`define TOC_COM_TOGGLE     2'h1
`define TOC_COM_CLEAR      2'h2
`define TOC_COM_SET        2'h3

// Extreme count values.
`define TOC_BOTTOM         8'h00
`define TOC_MAX            8'hFF

// Reset values.
`define TOC_RST_BYTE       8'h00
`define TOC_RST_WORD       32'h0000_0000

`endif

// ===== design/toc_pkg.sv
package toc_pkg;

   // Signals arriving from the counter unit, all on pclk.
   typedef struct packed {
      logic [7:0] count;        // Running count value.
      logic       tick;         // Timer clock enable, one cycle.
      logic       count_write;  // CPU wrote the count, one cycle.
      logic       at_top;       // Count equals top of the sequence.
      logic       count_down;   // Counter is counting down.
   } toc_cnt_t;

   // Pin drive toward the port pad, one per channel.
   typedef struct packed {
      logic out;                // Level driven to the pin.
      logic oe;                 // Pin driven while high.
   } toc_pin_t;

   // All state of the compare unit.
   typedef struct packed {
      logic [1:0][7:0] cmp_buf;     // Buffered compare values.
      logic [1:0][7:0] cmp_act;     // Active compare values.
      logic [1:0]      flag;        // Compare flags.
      logic [1:0]      out_state;   // Internal output state bits.
      logic [1:0]      irq_en;      // Interrupt enables.
      logic [1:0]      match_seen;  // Match taken on the last tick.
      logic            block;       // Suppress matches on the next tick.
      logic [2:0]      wgm;         // Waveform mode bits.
      logic [1:0][1:0] com;         // Compare output mode bits.
      logic [31:0]     prdata;      // Read data for the access phase.
   } toc_state_t;

endpackage

// ===== design/toc_compare_unit.sv
`timescale 1ns/1ps
`include "toc_defines.svh"

// How it works
// - Each channel compares the count with its active compare value continuously.
// - A match sets the channel flag one timer tick later.
// - An enabled flag requests an interrupt; servicing it clears the flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - Output state follows match, waveform mode, output mode, max and bottom.
// - Compare values are double buffered in PWM modes only.
// - Buffered values load into the active register at the sequence top.
// - Writes reach the buffer when buffering, else the active register.
// - Force strobe in non-PWM modes acts on the output as a match.
// - A forced compare sets no flag and leaves the counter alone.
// - A count write suppresses all matches on the next timer tick.
// - Output state bits keep their value across mode changes.
// - Output mode bits are not buffered and apply at once.
// - Reset clears each internal output state bit to zero.
// - Nonzero output mode makes the output state replace the port value.
// - Pin direction stays with the port direction bit.
// - Output mode zero leaves the output state unchanged on match.
// - New output mode acts at next match, or at once by force.
// - Output mode bits never influence the counting sequence.
// - PWM: output mode picks polarity; non-PWM: set, clear or toggle.
// - Mode 0 normal, 2 match clear, 3/7 fast, 1/5 phase correct.
// - Count 0x00 is bottom and 0xFF is max.
module toc_compare_unit (
   input  wire logic             pclk,         // Bus and timer clock.
   input  wire logic             presetn,      // Asynchronous reset, active low.
   input  wire logic             psel,         // APB select.
   input  wire logic             penable,      // APB enable.
   input  wire logic             pwrite,       // APB direction, high for write.
   input  wire logic [7:0]       paddr,        // APB byte address.
   input  wire logic [31:0]      pwdata,       // APB write data.
   output logic      [31:0]      prdata,       // APB read data.
   output logic                  pready,       // APB ready.
   output logic                  pslverr,      // APB error on unmapped address.
   input  wire toc_pkg::toc_cnt_t cnt,         // Counter unit status.
   input  wire logic [1:0]       irq_ack,      // Interrupt serviced, per channel.
   input  wire logic [1:0]       port_out,     // General port output value.
   input  wire logic [1:0]       port_dir,     // Port direction, high for output.
   output logic      [1:0]       irq,          // Compare interrupt requests.
   output toc_pkg::toc_pin_t [1:0] pin,        // Pin drive, A is index 0.
   output logic      [1:0]       compare_output_state // Internal output state.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode and waveform action.

   function automatic logic is_fast(input logic [2:0] wgm);
      is_fast = (wgm == `TOC_WGM_FAST) || (wgm == `TOC_WGM_FAST_TOP);
   endfunction

   function automatic logic is_phase(input logic [2:0] wgm);
      is_phase = (wgm == `TOC_WGM_PHASE) || (wgm == `TOC_WGM_PHASE_TOP);
   endfunction

   function automatic logic is_pwm(input logic [2:0] wgm);
      is_pwm = is_fast(wgm) || is_phase(wgm);
   endfunction

   // Next output state of one channel for one event.
   function automatic logic wave_next(
      input logic [2:0] wgm,
      input logic [1:0] com,
      input logic       chan_b,
      input logic       match,
      input logic       top_tick,
      input logic       down,
      input logic       cmp_max,
      input logic       cur
   );
      logic inv;
      inv       = com[0];
      wave_next = cur;
      if (com == `TOC_COM_OFF) begin
         wave_next = cur;
      end else if (!is_pwm(wgm)) begin
         if (match) begin
            unique case (com)
               `TOC_COM_TOGGLE: wave_next = ~cur;
               `TOC_COM_CLEAR:  wave_next = 1'b0;
               default:         wave_next = 1'b1;
            endcase
         end
      end else if (com == `TOC_COM_TOGGLE) begin
         // Toggle in PWM modes exists only for channel A with top set by compare A.
         if (match && wgm[2] && !chan_b) begin
            wave_next = ~cur;
         end
      end else if (is_fast(wgm)) begin
         // A compare value at max leaves a constant level; bottom sets polarity.
         if (match && !cmp_max) begin
            wave_next = inv;
         end
         if (top_tick) begin
            wave_next = ~inv;
         end
      end else begin
         if (match) begin
            wave_next = down ? ~inv : inv;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State update.

   toc_pkg::toc_state_t s;
   toc_pkg::toc_state_t next_s;

   logic       wr;
   logic       rd_setup;
   logic       mapped;
   logic [1:0] match_now;
   logic [1:0] hit;

   always_comb begin
      mapped = (paddr == `TOC_ADDR_CTRL) || (paddr == `TOC_ADDR_FORCE) ||
               (paddr == `TOC_ADDR_CMP_A) || (paddr == `TOC_ADDR_CMP_B) ||
               (paddr == `TOC_ADDR_FLAGS) || (paddr == `TOC_ADDR_IRQ_EN) ||
               (paddr == `TOC_ADDR_STATUS);
      wr       = psel && penable && pwrite;
      rd_setup = psel && !penable && !pwrite;
   end

   always_comb begin
      next_s = s;
      for (int c = 0; c < 2; c++) begin
         match_now[c] = (cnt.count == s.cmp_act[c]);
         hit[c]       = cnt.tick && match_now[c] && !s.block;
      end

      // Timer tick effects.
      if (cnt.tick) begin
         next_s.match_seen = hit;
         for (int c = 0; c < 2; c++) begin
            next_s.out_state[c] = wave_next(s.wgm, s.com[c], c == 1, hit[c],
                                            cnt.at_top, cnt.count_down,
                                            s.cmp_act[c] == `TOC_MAX,
                                            s.out_state[c]);
         end
         if (is_pwm(s.wgm) && cnt.at_top) begin
            next_s.cmp_act = s.cmp_buf;
         end
      end
      // A count write blocks the next tick; the blocking tick consumes it.
      if (cnt.count_write) begin
         next_s.block = 1'b1;
      end else if (cnt.tick) begin
         next_s.block = 1'b0;
      end

      // Flag clears from software and interrupt service; setting wins.
      for (int c = 0; c < 2; c++) begin
         if (irq_ack[c]) begin
            next_s.flag[c] = 1'b0;
         end
      end
      if (wr && paddr == `TOC_ADDR_FLAGS) begin
         next_s.flag = next_s.flag & ~pwdata[1:0];
      end
      if (cnt.tick) begin
         next_s.flag = next_s.flag | s.match_seen;
      end

      // Register writes.
      if (wr) begin
         unique case (paddr)
            `TOC_ADDR_CTRL: begin
               next_s.wgm    = pwdata[`TOC_CTRL_WGM_LSB +: 3];
               next_s.com[0] = pwdata[`TOC_CTRL_COMA_LSB +: 2];
               next_s.com[1] = pwdata[`TOC_CTRL_COMB_LSB +: 2];
            end
            `TOC_ADDR_FORCE: begin
               if (!is_pwm(s.wgm)) begin
                  for (int c = 0; c < 2; c++) begin
                     if (pwdata[c]) begin
                        next_s.out_state[c] = wave_next(s.wgm, s.com[c], c == 1,
                                                        1'b1, 1'b0, 1'b0, 1'b0,
                                                        next_s.out_state[c]);
                     end
                  end
               end
            end
            `TOC_ADDR_CMP_A, `TOC_ADDR_CMP_B: begin
               for (int c = 0; c < 2; c++) begin
                  if (paddr[2] == c[0]) begin
                     next_s.cmp_buf[c] = pwdata[7:0];
                     if (!is_pwm(s.wgm)) begin
                        next_s.cmp_act[c] = pwdata[7:0];
                     end
                  end
               end
            end
            `TOC_ADDR_IRQ_EN: begin
               next_s.irq_en = pwdata[1:0];
            end
            default: begin
            end
         endcase
      end

      // Read data is captured in the setup phase and held through the access.
      if (rd_setup) begin
         unique case (paddr)
            `TOC_ADDR_CTRL:   next_s.prdata = {24'h00_0000, s.com[1], s.com[0], 1'b0,
                                               s.wgm};
            `TOC_ADDR_CMP_A:  next_s.prdata = {24'h00_0000, is_pwm(s.wgm) ? s.cmp_buf[0]
                                               : s.cmp_act[0]};
            `TOC_ADDR_CMP_B:  next_s.prdata = {24'h00_0000, is_pwm(s.wgm) ? s.cmp_buf[1]
                                               : s.cmp_act[1]};
            `TOC_ADDR_FLAGS:  next_s.prdata = {30'h0000_0000, s.flag};
            `TOC_ADDR_IRQ_EN: next_s.prdata = {30'h0000_0000, s.irq_en};
            `TOC_ADDR_STATUS: next_s.prdata = {14'h0000, s.cmp_act[1], s.cmp_act[0],
                                               s.out_state};
            default:          next_s.prdata = `TOC_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   always_comb begin
      prdata               = s.prdata;
      pready               = 1'b1;
      pslverr              = psel && penable && !mapped;
      irq                  = s.flag & s.irq_en;
      compare_output_state = s.out_state;
      for (int c = 0; c < 2; c++) begin
         pin[c].out = (s.com[c] != `TOC_COM_OFF) ? s.out_state[c] : port_out[c];
         pin[c].oe  = port_dir[c];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   // Helper registers for the checks: what the next timer tick owes, kept apart from the state.
   logic [1:0] owe_flag;   // A match was taken on the last tick.
   logic       owe_block;  // A count write waits for its blocking tick.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         owe_flag  <= 2'b00;
         owe_block <= 1'b0;
      end else begin
         if (cnt.tick) begin
            owe_flag <= hit;
         end
         if (cnt.count_write) begin
            owe_block <= 1'b1;
         end else if (cnt.tick) begin
            owe_block <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_flag_follows_match: assert property (
      (cnt.tick && owe_flag[0]) |=> s.flag[0])
      else $error("Flag A not set on tick after match.");

   a_flag_follows_b: assert property (
      (cnt.tick && owe_flag[1]) |=> s.flag[1])
      else $error("Flag B not set on tick after match.");

   a_flag_not_early: assert property (
      (hit[1] && !s.flag[1] && !s.match_seen[1] && !s.block) |=> !s.flag[1])
      else $error("Flag B set in match cycle.");

   a_irq_gated: assert property (
      irq[0] |-> s.flag[0] && s.irq_en[0])
      else $error("Interrupt A without enabled flag.");

   a_ack_clears: assert property (
      (irq_ack[0] && !(cnt.tick && s.match_seen[0])) |=> !s.flag[0])
      else $error("Serviced flag A not cleared.");

   a_w1c_flag: assert property (
      (wr && paddr == `TOC_ADDR_FLAGS && pwdata[1] && !(cnt.tick && s.match_seen[1]))
      |=> !s.flag[1])
      else $error("Write one did not clear flag B.");

   a_block_after_write: assert property (
      (cnt.tick && owe_block) |-> hit == 2'b00)
      else $error("Match not suppressed after count write.");

   a_direct_write: assert property (
      (wr && paddr == `TOC_ADDR_CMP_A && !is_pwm(s.wgm)) |=> s.cmp_act[0] == $past(pwdata[7:0]))
      else $error("Direct compare write lost.");

   a_buffer_holds: assert property (
      (!(cnt.tick && cnt.at_top) && is_pwm(s.wgm))
      |=> $stable(s.cmp_act))
      else $error("Active compare changed off top.");

   a_force_no_flag: assert property (
      (wr && paddr == `TOC_ADDR_FORCE && !(cnt.tick && |s.match_seen) && !irq_ack[0]
       && !irq_ack[1]) |=> $stable(s.flag))
      else $error("Force changed a flag.");

   a_com_off_hold: assert property (
      (s.com[1] == `TOC_COM_OFF && !wr) |=> $stable(s.out_state[1]))
      else $error("Output B changed with mode off.");

   a_pin_override: assert property (
      pin[0].out == ((s.com[0] != `TOC_COM_OFF) ? s.out_state[0] : port_out[0]))
      else $error("Pin A source wrong.");

   a_pin_dir: assert property (
      pin[1].oe == port_dir[1])
      else $error("Pin B direction not from port.");

   a_irq_gated_b: assert property (
      irq[1] == (s.flag[1] && s.irq_en[1]))
      else $error("Interrupt B does not follow enabled flag.");

   a_ack_clears_b: assert property (
      (irq_ack[1] && !(cnt.tick && s.match_seen[1])) |=> !s.flag[1])
      else $error("Serviced flag B not cleared.");

   a_w1c_flag_a: assert property (
      (wr && paddr == `TOC_ADDR_FLAGS && pwdata[0] && !(cnt.tick && s.match_seen[0]))
      |=> !s.flag[0])
      else $error("Write one did not clear flag A.");

   a_direct_write_b: assert property (
      (wr && paddr == `TOC_ADDR_CMP_B && !is_pwm(s.wgm)) |=> s.cmp_act[1] == $past(pwdata[7:0]))
      else $error("Direct compare write B lost.");

   a_buffered_write: assert property (
      (wr && paddr == `TOC_ADDR_CMP_A && is_pwm(s.wgm)) |=> s.cmp_buf[0] == $past(pwdata[7:0]))
      else $error("Buffered compare write lost.");

   a_force_pwm_held: assert property (
      (wr && paddr == `TOC_ADDR_FORCE && is_pwm(s.wgm) && !cnt.tick) |=> $stable(s.out_state))
      else $error("Force acted in a PWM mode.");

   a_mode_keeps_state: assert property (
      (wr && paddr == `TOC_ADDR_CTRL && !cnt.tick) |=> $stable(s.out_state))
      else $error("Mode write changed an output state.");

   a_force_reads_zero: assert property (
      (rd_setup && paddr == `TOC_ADDR_FORCE) |=> prdata == 32'h0000_0000)
      else $error("Force register read not zero.");

   a_com_off_a: assert property (
      (s.com[0] == `TOC_COM_OFF && !wr) |=> $stable(s.out_state[0]))
      else $error("Output A changed with mode off.");

   a_pin_override_b: assert property (
      pin[1].out == ((s.com[1] != `TOC_COM_OFF) ? s.out_state[1] : port_out[1]))
      else $error("Pin B source wrong.");

   a_pin_dir_a: assert property (
      pin[0].oe == port_dir[0])
      else $error("Pin A direction not from port.");

   c_match_flag:  cover property (hit[0] ##[1:20] s.flag[0]);
   c_force_pin:   cover property (wr && paddr == `TOC_ADDR_FORCE ##1 $changed(s.out_state[0]));
   c_buffer_load: cover property (cnt.tick && cnt.at_top && is_pwm(s.wgm) && s.cmp_buf != s.cmp_act);
   c_blocked:     cover property (cnt.tick && s.block && |match_now);

endmodule

// ===== tb/toc_counter_model.sv
`timescale 1ns/1ps
// Counter unit stand-in: counts up on every other pclk while running and wraps at max.
module toc_counter_model (
   input  wire logic         pclk,    // Clock.
   input  wire logic         presetn, // Reset, active low.
   input  wire logic         run,     // Timer clock enabled.
   input  wire logic         wr,      // CPU count write, one cycle.
   input  wire logic [7:0]   wr_val,  // Value written to the count.
   output toc_pkg::toc_cnt_t cnt      // Counter status toward the compare unit.
);
   logic [7:0] count;
   logic       tick;
   logic       wrote;

   assign cnt = '{count: count, tick: tick, count_write: wrote,
                  at_top: (count == 8'hFF), count_down: 1'b0};

   // A CPU write wins over counting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 8'h00;
         tick  <= 1'b0;
         wrote <= 1'b0;
      end else begin
         tick  <= run & !tick;
         wrote <= wr;
         if (wr) begin
            count <= wr_val;
         end else if (tick) begin
            count <= count + 8'h01;
         end
      end
   end
endmodule

// ===== tb/test_toc_compare_unit.sv
`timescale 1ns/1ps
`include "toc_defines.svh"
module test_toc_compare_unit;
   logic                    pclk = 1'b0;
   logic                    presetn = 1'b0;
   logic                    psel = 1'b0;
   logic                    penable = 1'b0;
   logic                    pwrite = 1'b0;
   logic [7:0]              paddr = 8'h00;
   logic [31:0]             pwdata = 32'h0000_0000;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   toc_pkg::toc_cnt_t       cnt;
   logic [1:0]              irq_ack = 2'b00;
   logic [1:0]              port_out = 2'b00;
   logic [1:0]              port_dir = 2'b00;
   logic [1:0]              irq;
   toc_pkg::toc_pin_t [1:0] pin;
   logic [1:0]              compare_output_state;
   logic                    run = 1'b0;
   logic                    wr = 1'b0;
   logic [7:0]              wr_val = 8'h00;
   logic [31:0]             rd;
   logic                    er;
   logic [1:0]              s;
   int                      n_errors = 0;
   int                      checks = 0;

   always #12.5 pclk = ~pclk;

   toc_compare_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cnt(cnt), .irq_ack(irq_ack), .port_out(port_out),
      .port_dir(port_dir), .irq(irq), .pin(pin), .compare_output_state(compare_output_state));

   toc_counter_model partner (.pclk(pclk), .presetn(presetn), .run(run), .wr(wr),
      .wr_val(wr_val), .cnt(cnt));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Registered outputs settle before the caller looks at them.
      #1;
   endtask

   task automatic count_write(input logic [7:0] v);
      @(posedge pclk);
      wr     <= 1'b1;
      wr_val <= v;
      @(posedge pclk);
      wr     <= 1'b0;
   endtask

   // Waits for an output state bit to change, at most lim cycles.
   task automatic wait_state(input int lim);
      logic old;
      old = compare_output_state[0];
      for (int i = 0; i < lim && compare_output_state[0] === old; i++) begin
         @(posedge pclk);
         #1;
      end
      chk({31'd0, compare_output_state[0]}, {31'd0, ~old}, "match changes state");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      apb(1'b0, `TOC_ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "status after reset");
      apb(1'b0, `TOC_ADDR_FORCE, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "force reads zero");
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk({31'd0, er}, 32'h0000_0001, "unmapped error");
   endtask

   task automatic t_force;
      logic [31:0] tbl [5][3] = '{'{32'h10, 32'h1, 32'h1}, '{32'h20, 32'h1, 32'h0},
         '{32'h30, 32'h3, 32'h1}, '{32'h72, 32'h3, 32'h3}, '{32'h22, 32'h3, 32'h2}};
      foreach (tbl[i]) begin
         apb(1'b1, `TOC_ADDR_CTRL, tbl[i][0]);
         apb(1'b1, `TOC_ADDR_FORCE, tbl[i][1]);
         chk({30'd0, compare_output_state}, tbl[i][2], "forced action");
      end
      apb(1'b0, `TOC_ADDR_FLAGS, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "force sets no flag");
      @(posedge pclk);
      port_out <= 2'b11;
      port_dir <= 2'b01;
      @(posedge pclk);
      #1;
      chk({30'd0, pin[0].out, pin[1].out}, 32'h0000_0001, "pin override");
      chk({30'd0, pin[0].oe, pin[1].oe}, 32'h0000_0002, "pin direction");
   endtask

   task automatic t_match;
      apb(1'b1, `TOC_ADDR_CTRL, 32'h0000_0010);
      apb(1'b1, `TOC_ADDR_CMP_A, 32'h0000_0010);
      apb(1'b1, `TOC_ADDR_IRQ_EN, 32'h0000_0001);
      count_write(8'h08);
      run <= 1'b1;
      wait_state(100);
      chk({31'd0, irq[0]}, 32'h0000_0000, "flag not yet set");
      repeat (2) @(posedge pclk);
      #1;
      chk({30'd0, irq}, 32'h0000_0001, "flag one tick later");
      apb(1'b1, `TOC_ADDR_FLAGS, 32'h0000_0000);
      apb(1'b0, `TOC_ADDR_FLAGS, 32'h0000_0000);
      chk(rd, 32'h0000_0001, "zero write keeps flag");
      apb(1'b1, `TOC_ADDR_FLAGS, 32'h0000_0001);
      apb(1'b0, `TOC_ADDR_FLAGS, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "one write clears flag");
      wait_state(600);
      repeat (2) @(posedge pclk);
      irq_ack <= 2'b01;
      @(posedge pclk);
      irq_ack <= 2'b00;
      #1;
      chk({31'd0, irq[0]}, 32'h0000_0000, "service clears flag");
   endtask

   task automatic t_block;
      @(posedge pclk);
      run <= 1'b0;
      apb(1'b1, `TOC_ADDR_CMP_A, 32'h0000_0030);
      apb(1'b0, `TOC_ADDR_STATUS, 32'h0000_0000);
      chk({24'd0, rd[9:2]}, 32'h0000_0030, "direct write");
      s = compare_output_state;
      count_write(8'h30);
      run <= 1'b1;
      repeat (6) @(posedge pclk);
      #1;
      chk({30'd0, compare_output_state}, {30'd0, s}, "match blocked");
      @(posedge pclk);
      run <= 1'b0;
   endtask

   task automatic t_buffer;
      repeat (2) @(posedge pclk);
      s = compare_output_state;
      apb(1'b1, `TOC_ADDR_CTRL, 32'h0000_0023);
      apb(1'b1, `TOC_ADDR_FORCE, 32'h0000_0001);
      chk({30'd0, compare_output_state}, {30'd0, s}, "state kept, force ignored");
      apb(1'b1, `TOC_ADDR_CTRL, 32'h0000_0003);
      chk({31'd0, pin[0].out}, 32'h0000_0001, "mode bits apply at once");
      apb(1'b1, `TOC_ADDR_CTRL, 32'h0000_0023);
      apb(1'b1, `TOC_ADDR_CMP_A, 32'h0000_0050);
      apb(1'b0, `TOC_ADDR_CMP_A, 32'h0000_0000);
      chk(rd, 32'h0000_0050, "buffer read");
      apb(1'b0, `TOC_ADDR_STATUS, 32'h0000_0000);
      chk({24'd0, rd[9:2]}, 32'h0000_0030, "active held");
      @(posedge pclk);
      run <= 1'b1;
      for (int i = 0; i < 700 && !(cnt.tick && cnt.at_top); i++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      apb(1'b0, `TOC_ADDR_STATUS, 32'h0000_0000);
      chk({24'd0, rd[9:2]}, 32'h0000_0050, "loaded at top");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(25ns * 20000);
      n_errors++;
      conclude();
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_force();
      t_match();
      t_block();
      t_buffer();
      conclude();
   end
endmodule
